// ### hdl/srd_phase.v
// Four-phase counter that splits each instruction cycle
`timescale 1ns/1ps
`include "srd_regs.vh"
module srd_phase (
    input wire clk,
    input wire reset,
    output reg [1:0] phase_q
);
    // Phase advances one step per clock, wraps after the fourth
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            phase_q <= `SRD_PH_Q1;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end
endmodule // srd_phase

// ### hdl/srd_regs.vh
// Constants of the subroutine return decoder
`ifndef SRD_REGS_VH
`define SRD_REGS_VH
`define SRD_INSTR_W 14
`define SRD_DATA_W 8
`define SRD_PC_W 13
`define SRD_LIT_TOP 4'hd
`define SRD_LIT_MASK 4'hf
`define SRD_RET_OPC 14'h0008
`define SRD_PH_Q1 2'h0
`define SRD_PH_Q2 2'h1
`define SRD_PH_Q3 2'h2
`define SRD_PH_Q4 2'h3
`endif

// ### hdl/srd_return_decode.v
// Decoder and sequencer for the two subroutine return instructions
// Function
// - Recognise literal return: 11 01xx kkkkkkkk
// - Literal return writes immediate byte to accumulator
// - Literal return pops stack top into counter
// - Two cycles: read k Q2, write/pop Q4
// - Recognise plain return opcode 00000000001000
// - Neither return changes any status flag
`timescale 1ns/1ps
`include "srd_regs.vh"
module srd_return_decode (
    input wire clk,
    input wire reset,
    input wire [13:0] instr,
    input wire [12:0] stack_top,
    output reg [1:0] phase_q,
    output reg [7:0] acc_q,
    output reg acc_we_q,
    output reg stack_pop_q,
    output reg [12:0] program_counter_q,
    output reg pc_load_q,
    output reg flush_q,
    output reg busy_q,
    output reg status_we_q
);
    // Sequencer states: the first cycle executes, the second idles
    localparam ST_EXEC = 2'h0;
    localparam ST_IDLE = 2'h1;

    // Internal phase, one clock ahead of the registered copy on the port
    wire [1:0] phase_w;

    // Sequencer state and its next value
    reg [1:0] state_q;
    reg [1:0] state_d;

    // Literal byte, held from its Q2 read until the Q4 write
    reg [7:0] lit_q;

    // Decoded instruction kind, captured in Q1 of the execute cycle
    reg is_lit_q;
    reg is_ret_q;

    // Raw opcode matches on the current instruction word
    wire lit_hit;
    wire ret_hit;

    // Phase strobes qualified by the sequencer state
    wire exec_q1;
    wire exec_q2;
    wire exec_q4;
    wire idle_q4;

    // Either return kind is in flight
    wire ret_any;

    // Phase generator that paces all sequencing below
    srd_phase u_phase (
        .clk(clk),
        .reset(reset),
        .phase_q(phase_w)
    );

    // Opcode match: literal return ignores bits 9:8 and the low byte
    assign lit_hit = (instr[13:10] == `SRD_LIT_TOP);
    assign ret_hit = (instr == `SRD_RET_OPC);

    // Phase strobes; the idle cycle never decodes, so a word fetched there is dropped
    assign exec_q1 = (state_q == ST_EXEC) && (phase_w == `SRD_PH_Q1);
    assign exec_q2 = (state_q == ST_EXEC) && (phase_w == `SRD_PH_Q2);
    assign exec_q4 = (state_q == ST_EXEC) && (phase_w == `SRD_PH_Q4);
    assign idle_q4 = (state_q == ST_IDLE) && (phase_w == `SRD_PH_Q4);

    // A return of either kind was decoded in this cycle
    assign ret_any = is_lit_q || is_ret_q;

    // Next state: a return enters the idle cycle after its Q4
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_EXEC: begin
                if (phase_w == `SRD_PH_Q4 && ret_any) begin
                    state_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (phase_w == `SRD_PH_Q4) begin
                    state_d = ST_EXEC;
                end
            end
            default: begin
                state_d = ST_EXEC;
            end
        endcase
    end

    // State register
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= ST_EXEC;
        end else begin
            state_q <= state_d;
        end
    end

    // Registered phase for the port, so the output comes from a flop
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            phase_q <= `SRD_PH_Q1;
        end else begin
            phase_q <= phase_w;
        end
    end

    // Decode latch: kind captured in Q1, cleared at the end of the idle cycle
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            is_lit_q <= 1'b0;
            is_ret_q <= 1'b0;
        end else if (exec_q1) begin
            is_lit_q <= lit_hit;
            is_ret_q <= ret_hit;
        end else if (idle_q4) begin
            is_lit_q <= 1'b0;
            is_ret_q <= 1'b0;
        end
    end

    // Literal read in Q2; the word only has to stand through Q1 and Q2
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            lit_q <= 8'h00;
        end else if (exec_q2 && is_lit_q) begin
            lit_q <= instr[7:0];
        end
    end

    // Accumulator write in Q4 of a literal return
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            acc_q <= 8'h00;
            acc_we_q <= 1'b0;
        end else begin
            acc_we_q <= exec_q4 && is_lit_q;
            if (exec_q4 && is_lit_q) begin
                acc_q <= lit_q;
            end
        end
    end

    // Stack pop request, one clock wide, in Q4 of either return
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            stack_pop_q <= 1'b0;
        end else begin
            stack_pop_q <= exec_q4 && ret_any;
        end
    end

    // Return address taken from the stack top at the same edge as the pop
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            program_counter_q <= 13'h0000;
            pc_load_q <= 1'b0;
        end else begin
            pc_load_q <= exec_q4 && ret_any;
            if (exec_q4 && ret_any) begin
                program_counter_q <= stack_top;
            end
        end
    end

    // Flush covers the whole idle cycle so the stale prefetch never executes
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            flush_q <= 1'b0;
        end else begin
            flush_q <= (state_d == ST_IDLE);
        end
    end

    // Busy marks the second, idle cycle of a return
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (state_d == ST_IDLE);
        end
    end

    // Status write is never requested by either return
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            status_we_q <= 1'b0;
        end else begin
            status_we_q <= 1'b0;
        end
    end

    // Limitation: an instruction presented during the idle cycle is ignored;
    // the fetch path must present the word at the restored counter instead.
    // Hazard avoided: the decode latch is cleared at the last idle edge, so a
    // return can never pop twice even if the word is held across both cycles.
    // Trade: one extra flop per output keeps every port free of decode glitches,
    // at the cost of a one-clock lag between internal phase and the phase port.
endmodule // srd_return_decode

// ### verif/srd_monitor.sv
// Return decoder checker
`timescale 1ns/1ps
module srd_monitor(input wire clk,reset,acc_we_q,stack_pop_q,pc_load_q,flush_q,busy_q,status_we_q,
    input wire [13:0] instr,input wire [12:0] stack_top,program_counter_q,input wire [1:0] phase_q,input wire [7:0] acc_q);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire d=phase_q==2'h3&&!flush_q;
    lit_acc_a:assert property(d&&instr[13:10]==4'hd|->##4 acc_q==$past(instr[7:0],4))else $error("lit");
    ret_pop_a:assert property(d&&instr==14'h0008|->##4 stack_pop_q&&!acc_we_q)else $error("ret");
    other_op_a:assert property(d&&instr[13:10]!=4'hd&&instr!=14'h0008|->##4!stack_pop_q)else $error("op");
    pc_top_a:assert property(pc_load_q|->program_counter_q==$past(stack_top))else $error("pc");
    pop_phase_a:assert property(stack_pop_q|->pc_load_q&&busy_q&&phase_q==2'h3)else $error("ph");
    pop_once_a:assert property(stack_pop_q|=>!stack_pop_q)else $error("pop");
    flag_hold_a:assert property(!status_we_q)else $error("flag");
    idle_len_a:assert property($rose(flush_q)|->flush_q[*4]##1!flush_q)else $error("idle");
    cover property(acc_we_q);
    cover property(stack_pop_q&&!acc_we_q);
    cover property($fell(flush_q));
endmodule // srd_monitor
bind srd_return_decode srd_monitor u_mon(.clk(clk),.reset(reset),.acc_we_q(acc_we_q),.stack_pop_q(stack_pop_q),
    .pc_load_q(pc_load_q),.flush_q(flush_q),.busy_q(busy_q),.status_we_q(status_we_q),.instr(instr),
    .stack_top(stack_top),.program_counter_q(program_counter_q),.phase_q(phase_q),.acc_q(acc_q));

// ### verif/srd_stack.sv
// Return stack model
`timescale 1ns/1ps
module srd_stack(input wire clk,reset,stack_pop_q,output reg [12:0] stack_top);
    // Next entry shows after a pop
    always @(posedge clk or posedge reset) stack_top<=reset?13'h1abc:stack_top-{stack_pop_q,4'h0};
endmodule // srd_stack

// ### verif/testbench.sv
// Return decoder bench
`timescale 1ns/1ps
`define C(a,b) begin checks++;if((a)!==(b))begin err_count++;$display("[FAIL] %0t %h %h",$time,a,b);end end
module testbench;
    reg clk=1'h0,reset=1'h1;
    reg [13:0] instr=14'h0;
    wire [12:0] stack_top,program_counter_q;
    wire [7:0] acc_q;
    wire [1:0] phase_q;
    wire acc_we_q,stack_pop_q,pc_load_q,flush_q,busy_q,status_we_q;
    wire [5:0] flags={acc_we_q,stack_pop_q,pc_load_q,flush_q,busy_q,status_we_q};
    reg [12:0] ea=13'h0,ep=13'h0,et=13'h1abc;
    int err_count=0,checks=0;
    srd_return_decode u_dut(.*);
    srd_stack u_stk(.*);
    // Clock
    always #2.5 clk=~clk;
    task op(input [13:0] v,input l,p);
        while(phase_q!==2'h2)@(negedge clk);
        @(posedge clk)instr<=v;
        {ea,ep,et}={l?v[7:0]:ea,p?{et,et-13'h10}:{ep,et}};
        repeat(5)@(negedge clk);
        `C({flags,acc_q,program_counter_q},{l,{4{p}},1'h0,ea[7:0],ep})
        repeat(4)@(posedge clk);
        instr<=14'h0;
        @(negedge clk)`C(flags[4:1],4'h0)
    endtask
    task t_returns;
        op(14'h37ff,1'h1,1'h1);
        op(14'h3400,1'h1,1'h1);
        op(14'h0008,1'h0,1'h1);
        op(14'h3800,1'h0,1'h0);
    endtask
    task report_and_stop;
        if(err_count==0&&checks>0)$display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Guard
    initial begin
        #5000 err_count++;
        report_and_stop;
    end
    // Main
    initial begin
        repeat(4)@(posedge clk);
        reset<=1'h0;
        t_returns;
        report_and_stop;
    end
endmodule // testbench
